/* File: verilog/sensor_channel_status_bank.sv */
// channel status and result register bank with wishbone slave, read-only except the interrupt enable and clear registers
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1: on proximity event, latch proximity state of all channels, 1 means in proximity
// RULE2: set direction bit when trigger happens with count above long-term average
// RULE3: clear direction bit when trigger happens with count below long-term average
// RULE4: on touch event, latch touch state of every channel, 1 means touched
// RULE5: on deep-touch event, latch deep-touch state of every channel
// RULE6: on reference event, report which configured reference channels are in use
// RULE7: set minimum compensation flag when tuning assigns compensation zero
// RULE8: set maximum compensation flag when tuning assigns compensation 1024
// RULE9: with six-element trackpad, X coordinate is limited to 0..128
// RULE10: with nine-element trackpad, X coordinate spans 0..255
// RULE11: for either trackpad layout, Y coordinate spans 0..255
// RULE12: expose raw count of wake, trackpad and general channels
// RULE13: long-term average follows counts by slow IIR filter while inactive
// RULE14: long-term average is frozen while a channel is active; the code still seeds it from a slot's first sample even when active
// RULE15: Hall output is the difference between the two plate counts
// RULE16: Hall common is the shared baseline of the two plates
// RULE17: both Hall plate filtered counts are separately readable
// RULE18: per-channel tuning result drives the compensation limit flags
// RULE19: all bank registers are read-only, host writes leave them unchanged; writes still load the interrupt enable and clear interrupt status bits
module sensor_channel_status_bank #(
    parameter int CHANNELS  = 13,
    parameter int LTA_SHIFT = 4
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // state events from the sensing engine
    input  wire logic        prox_event_i,
    input  wire logic [7:0]  prox_state_i,
    input  wire logic        touch_event_i,
    input  wire logic [7:0]  touch_state_i,
    input  wire logic        deep_event_i,
    input  wire logic [7:0]  deep_state_i,
    input  wire logic        ref_event_i,
    input  wire logic [7:0]  ref_config_i,
    input  wire logic [7:0]  ref_active_i,
    // channel samples
    input  wire logic        sample_valid_i,
    input  wire logic [3:0]  sample_chan_i,
    input  wire logic [15:0] sample_count_i,
    input  wire logic        sample_active_i,
    input  wire logic        sample_trigger_i,
    // auto tuning results
    input  wire logic        tune_done_i,
    input  wire logic [2:0]  tune_bit_i,
    input  wire logic [10:0] tune_comp_i,
    // trackpad coordinates
    input  wire logic        coord_valid_i,
    input  wire logic        tp_layout_3x3_i,
    input  wire logic [7:0]  coord_x_i,
    input  wire logic [7:0]  coord_y_i,
    // magnetic channel plates
    input  wire logic        hall_valid_i,
    input  wire logic [15:0] plate0_count_i,
    input  wire logic [15:0] plate1_count_i,
    // interrupt
    output logic             irq_o
);

    // ********************************
    // storage
    // ********************************
    // event-latched group masks: bit 0 wake, 1 trackpad, 4 to 6 general, 7 magnetic
    logic [7:0]          prox_q;     // proximity state per group
    logic [7:0]          dir_q;      // trigger direction per group
    logic [7:0]          touch_q;    // touch state per group
    logic [7:0]          deep_q;     // deep-touch state per group
    logic [7:0]          ref_q;      // reference channels in use
    logic [7:0]          cmin_q;     // compensation at bottom limit
    logic [7:0]          cmax_q;     // compensation at top limit
    logic [7:0]          x_q;        // trackpad X
    logic [7:0]          y_q;        // trackpad Y
    // per-slot counts and averages: slot 0 wake, 1 to 9 trackpad, 10 to 12 general
    logic [15:0]         cnt_q [CHANNELS];
    logic [15:0]         lta_q [CHANNELS];
    logic [CHANNELS-1:0] seeded_q;   // average holds a real value
    logic [15:0]         hall_out_q; // plate difference
    logic [15:0]         hall_com_q; // plate baseline
    logic [15:0]         plate0_q;
    logic [15:0]         plate1_q;
    logic [6:0]          irq_stat_q; // sticky event bits
    logic [6:0]          irq_en_q;
    logic [6:0]          irq_set;
    logic [6:0]          irq_clr;
    logic                req;        // request taken at this edge
    logic                wr;
    logic                en_wr;      // write to the enable register
    logic                clr_wr;     // write to the clear register
    logic                hit;
    logic [7:0]          idx;
    logic [31:0]         rd_d;

    // map a count slot onto its channel group bit
    // all trackpad slots share one group bit, so any pad element moves it
    function automatic logic [2:0] slot_bit(input logic [3:0] slot);
        if (slot == 4'h0) begin
            slot_bit = 3'(status_bank_pkg::BIT_WAKE);
        end else if (slot <= 4'(status_bank_pkg::TP_LAST)) begin
            slot_bit = 3'(status_bank_pkg::BIT_TRACKPAD);
        end else begin
            slot_bit = 3'(status_bank_pkg::BIT_GEN0 + int'(slot) - status_bank_pkg::GEN_FIRST);
        end
    endfunction

    // one filter step toward the new count
    // the arithmetic shift lets the average fall as well as rise; rising steps under one
    // count are lost, so the average may settle up to 15 counts below a steady input
    function automatic logic [15:0] lta_step(input logic [15:0] avg, input logic [15:0] cnt);
        logic signed [16:0] diff;
        diff = $signed({1'b0, cnt}) - $signed({1'b0, avg});
        lta_step = 16'($signed({1'b0, avg}) + (diff >>> LTA_SHIFT));
    endfunction

    // count slot addressed by a word index, counts and averages interleaved
    function automatic logic [3:0] cnt_slot(input logic [7:0] index);
        cnt_slot = 4'((index - status_bank_pkg::IDX_CNT_FIRST) >> 1);
    endfunction

    // ********************************
    // bus decode
    // ********************************
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // only byte lane 0 gates a write, the writable registers are seven bits wide
    assign wr  = req & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    // the two writable targets
    assign en_wr  = wr && idx == status_bank_pkg::IDX_IRQ_EN;
    assign clr_wr = wr && idx == status_bank_pkg::IDX_IRQ_CLR;

    // single-cycle acknowledge, dropped the cycle after
    // the ~ack term in req keeps a held request from being taken twice
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // ********************************
    // channel state registers
    // ********************************
    // proximity snapshot of all groups
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prox_q <= status_bank_pkg::RST_BYTE;
        end else if (prox_event_i) begin
            prox_q <= prox_state_i; // see RULE1
        end
    end

    // touch snapshot of all groups
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            touch_q <= status_bank_pkg::RST_BYTE;
        end else if (touch_event_i) begin
            touch_q <= touch_state_i; // see RULE4
        end
    end

    // deep-touch snapshot of all groups
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            deep_q <= status_bank_pkg::RST_BYTE;
        end else if (deep_event_i) begin
            deep_q <= deep_state_i; // see RULE5
        end
    end

    // reference channels in use, masked by what is configured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_q <= status_bank_pkg::RST_BYTE;
        end else if (ref_event_i) begin
            ref_q <= ref_active_i & ref_config_i; // see RULE6
        end
    end

    // trigger direction against the stored long-term average
    // an equal count leaves the bit; an unseeded average reads zero, so a first-sample trigger sets it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q <= status_bank_pkg::RST_BYTE;
        end else if (sample_valid_i && sample_trigger_i && int'(sample_chan_i) < CHANNELS) begin
            if (sample_count_i > lta_q[sample_chan_i]) begin
                dir_q[slot_bit(sample_chan_i)] <= 1'b1; // see RULE2
            end else if (sample_count_i < lta_q[sample_chan_i]) begin
                dir_q[slot_bit(sample_chan_i)] <= 1'b0; // see RULE3
            end
        end
    end

    // bottom-limit flag, rewritten by every tuning result of its group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmin_q <= status_bank_pkg::RST_BYTE;
        end else if (tune_done_i) begin // see RULE18
            cmin_q[tune_bit_i] <= (tune_comp_i == status_bank_pkg::COMP_MIN); // see RULE7
        end
    end

    // top-limit flag, rewritten too so a retuned group loses a stale flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmax_q <= status_bank_pkg::RST_BYTE;
        end else if (tune_done_i) begin // see RULE18
            cmax_q[tune_bit_i] <= (tune_comp_i == status_bank_pkg::COMP_MAX); // see RULE8
        end
    end

    // X coordinate, clamped for the six-element layout only
    // larger raw values are held at the edge rather than wrapped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            x_q <= status_bank_pkg::RST_BYTE;
        end else if (coord_valid_i) begin
            if (!tp_layout_3x3_i && coord_x_i > status_bank_pkg::X_MAX_2X3) begin
                x_q <= status_bank_pkg::X_MAX_2X3; // see RULE9
            end else begin
                x_q <= coord_x_i; // see RULE10
            end
        end
    end

    // Y coordinate, full byte range for both layouts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            y_q <= status_bank_pkg::RST_BYTE;
        end else if (coord_valid_i) begin
            y_q <= coord_y_i; // see RULE11
        end
    end

    // ********************************
    // counts and long-term averages
    // ********************************
    // raw counts per slot; average seeds on first sample, then filters
    // seeding spares the average a long climb from zero; slots at or above CHANNELS are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seeded_q <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                cnt_q[i] <= status_bank_pkg::RST_WORD;
                lta_q[i] <= status_bank_pkg::RST_WORD;
            end
        end else if (sample_valid_i && int'(sample_chan_i) < CHANNELS) begin
            cnt_q[sample_chan_i] <= sample_count_i; // see RULE12
            if (!seeded_q[sample_chan_i]) begin
                lta_q[sample_chan_i]    <= sample_count_i;
                seeded_q[sample_chan_i] <= 1'b1;
            end else if (!sample_active_i) begin
                lta_q[sample_chan_i] <= lta_step(lta_q[sample_chan_i], sample_count_i); // see RULE13
            end // active: average held, see RULE14
        end
    end

    // ********************************
    // magnetic channel outputs
    // ********************************
    // difference and baseline mean; the sum keeps a carry bit so the mean cannot wrap
    // the difference wraps modulo 2^16, so a negative offset reads as two's complement
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hall_out_q <= status_bank_pkg::RST_WORD;
            hall_com_q <= status_bank_pkg::RST_WORD;
        end else if (hall_valid_i) begin
            hall_out_q <= plate0_count_i - plate1_count_i; // see RULE15
            hall_com_q <= 16'(({1'b0, plate0_count_i} + {1'b0, plate1_count_i}) >> 1); // see RULE16
        end
    end

    // plate counts as delivered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            plate0_q <= status_bank_pkg::RST_WORD;
            plate1_q <= status_bank_pkg::RST_WORD;
        end else if (hall_valid_i) begin
            plate0_q <= plate0_count_i; // see RULE17
            plate1_q <= plate1_count_i; // see RULE17
        end
    end

    // ********************************
    // interrupts
    // ********************************
    // status bit order follows the event inputs, proximity in bit 0
    assign irq_set = {hall_valid_i, coord_valid_i, tune_done_i, ref_event_i,
                      deep_event_i, touch_event_i, prox_event_i};
    assign irq_clr = clr_wr ? wb_dat_i[6:0] : 7'h00;

    // sticky status, a new event beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= status_bank_pkg::RST_IRQ;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    // enable register, the only writable storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_q <= status_bank_pkg::RST_IRQ;
        end else if (en_wr) begin
            irq_en_q <= wb_dat_i[6:0];
        end
    end

    // level interrupt, registered so it trails a status or enable change by one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_en_q);
        end
    end

    // ********************************
    // read multiplexer
    // ********************************
    // writes to bank registers other than the enable and clear registers are ignored, see RULE19
    // unmapped indices and the clear register read as zero
    always_comb begin
        rd_d = 32'h0000_0000;
        hit  = 1'b1;
        case (idx)
            status_bank_pkg::IDX_PROX:     rd_d[15:0] = {dir_q, prox_q};
            status_bank_pkg::IDX_TOUCH:    rd_d[15:0] = {deep_q, touch_q};
            status_bank_pkg::IDX_REF_USED: rd_d[15:0] = {8'h00, ref_q};
            status_bank_pkg::IDX_COMP:     rd_d[15:0] = {cmax_q, cmin_q};
            status_bank_pkg::IDX_COORD:    rd_d[15:0] = {y_q, x_q};
            status_bank_pkg::IDX_HALL_OUT: rd_d[15:0] = hall_out_q;
            status_bank_pkg::IDX_HALL_COM: rd_d[15:0] = hall_com_q;
            status_bank_pkg::IDX_PLATE0:   rd_d[15:0] = plate0_q;
            status_bank_pkg::IDX_PLATE1:   rd_d[15:0] = plate1_q;
            status_bank_pkg::IDX_IRQ_STAT: rd_d[6:0]  = irq_stat_q;
            status_bank_pkg::IDX_IRQ_EN:   rd_d[6:0]  = irq_en_q;
            default: hit = 1'b0;
        endcase
        if (!hit && idx >= status_bank_pkg::IDX_CNT_FIRST && idx <= status_bank_pkg::IDX_CNT_LAST) begin
            if (idx[0]) begin
                rd_d[15:0] = cnt_q[cnt_slot(idx)];
            end else begin
                rd_d[15:0] = lta_q[cnt_slot(idx)];
            end
        end
    end

    // registered read data, held through write cycles until the next read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= rd_d;
        end
    end

endmodule // sensor_channel_status_bank

`default_nettype wire

/* File: verilog/status_bank_pkg.sv */
// constants shared by the channel status register bank
package status_bank_pkg;
    // ********************************
    // register indices (byte address = 4 * index)
    // ********************************
    localparam logic [7:0] IDX_PROX      = 8'h04;
    localparam logic [7:0] IDX_TOUCH     = 8'h05;
    localparam logic [7:0] IDX_REF_USED  = 8'h06;
    localparam logic [7:0] IDX_COMP      = 8'h07;
    localparam logic [7:0] IDX_COORD     = 8'h08;
    localparam logic [7:0] IDX_CNT_FIRST = 8'h09;
    localparam logic [7:0] IDX_CNT_LAST  = 8'h22;
    localparam logic [7:0] IDX_HALL_OUT  = 8'h23;
    localparam logic [7:0] IDX_HALL_COM  = 8'h24;
    localparam logic [7:0] IDX_PLATE0    = 8'h25;
    localparam logic [7:0] IDX_PLATE1    = 8'h26;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h30;
    localparam logic [7:0] IDX_IRQ_EN    = 8'h31;
    localparam logic [7:0] IDX_IRQ_CLR   = 8'h32;
    // ********************************
    // channel group bit positions
    // ********************************
    localparam int BIT_WAKE     = 0;
    localparam int BIT_TRACKPAD = 1;
    localparam int BIT_GEN0     = 4;
    localparam int BIT_MAGNETIC = 7;
    localparam int TP_FIRST     = 1; // count slot of first trackpad channel
    localparam int TP_LAST      = 9;
    localparam int GEN_FIRST    = 10;
    // ********************************
    // interrupt status bit positions
    // ********************************
    localparam int IRQ_PROX  = 0;
    localparam int IRQ_TOUCH = 1;
    localparam int IRQ_DEEP  = 2;
    localparam int IRQ_REF   = 3;
    localparam int IRQ_COMP  = 4;
    localparam int IRQ_COORD = 5;
    localparam int IRQ_HALL  = 6;
    localparam int IRQ_BITS  = 7;
    // ********************************
    // values and reset values
    // ********************************
    localparam logic [10:0] COMP_MIN   = 11'h000;
    localparam logic [10:0] COMP_MAX   = 11'h400;
    localparam logic [7:0]  X_MAX_2X3  = 8'h80;
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [6:0]  RST_IRQ    = 7'h00;
endpackage

/* File: verification/status_bank_asserts.sv */
// assertion checker for the channel status register bank
`timescale 1ns/1ps
`default_nettype none
module status_bank_checker #(
    parameter int CHANNELS  = 13,
    parameter int LTA_SHIFT = 4
) (
    // watched ports
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        tp_layout_3x3_i,
    input wire logic        irq_o
);
    // request taken at this edge
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus handshake
    a_ack_prompt: assert property (req |=> wb_ack_o) else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack without request");
    // read data
    a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
    a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i[9:2] == 8'h3F |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_x_clamp: assert property (req && !wb_we_i && wb_adr_i[9:2] == 8'h08 && !tp_layout_3x3_i
        |=> wb_dat_o[7:0] <= 8'h80) else $error("x above 128 on small pad");
    // interrupt
    a_irq_reset: assert property ($fell(rst_i) |-> !irq_o) else $error("irq high out of reset");
endmodule // status_bank_checker

bind sensor_channel_status_bank status_bank_checker #(.CHANNELS(CHANNELS), .LTA_SHIFT(LTA_SHIFT)) checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tp_layout_3x3_i(tp_layout_3x3_i),
    .irq_o(irq_o));
`default_nettype wire

/* File: verification/wb_host.sv */
// host model: classic wishbone master reaching the bank
`timescale 1ns/1ps
`default_nettype none
module wb_host (
    // clock
    input  wire logic        clk_i,
    // wishbone master
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [9:0]  adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    logic late;
    initial begin
        {cyc_o, stb_o, we_o, late} = 4'h0;
        adr_o = 10'h3FF;
        sel_o = 4'h0;
        dat_o = 32'h00000000;
    end
    // one transfer; address and data lines show inverted values once released
    task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_o, stb_o, we_o} <= {2'b11, w};
        adr_o <= {i, 2'b00};
        sel_o <= 4'hF;
        dat_o <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 50);
        rd = dat_i;
        late = (ack_i !== 1'b1);
        {cyc_o, stb_o} <= 2'b00;
        adr_o <= ~{i, 2'b00};
        dat_o <= ~wd;
    endtask
endmodule // wb_host
`default_nettype wire

/* File: verification/test_sensor_channel_status_bank.sv */
// self-checking bench for the channel status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin error_cnt++; $display("unexpected %s exp %h got %h", n, e, a); end end
module test_sensor_channel_status_bank;
    logic clk_i, rst_i, cyc, stb, we, ack, irq_o, act, trig, lay;
    logic [9:0] adr;
    logic [3:0] sel, chan;
    logic [31:0] wdat, rdat;
    logic [7:0] ev, pst, tst, dst, rcf, rac, cx, cy;
    logic [15:0] cnt, p0, p1;
    logic [2:0] tbit;
    logic [10:0] comp;
    int error_cnt = 0;
    int check_count = 0;
    // ********************************
    // design, host model, clock
    // ********************************
    sensor_channel_status_bank sensor_channel_status_bank_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .prox_event_i(ev[0]), .prox_state_i(pst), .touch_event_i(ev[1]),
        .touch_state_i(tst), .deep_event_i(ev[2]), .deep_state_i(dst), .ref_event_i(ev[3]), .ref_config_i(rcf),
        .ref_active_i(rac), .sample_valid_i(ev[4]), .sample_chan_i(chan), .sample_count_i(cnt),
        .sample_active_i(act), .sample_trigger_i(trig), .tune_done_i(ev[5]), .tune_bit_i(tbit),
        .tune_comp_i(comp), .coord_valid_i(ev[6]), .tp_layout_3x3_i(lay), .coord_x_i(cx), .coord_y_i(cy),
        .hall_valid_i(ev[7]), .plate0_count_i(p0), .plate1_count_i(p1), .irq_o(irq_o));
    wb_host wb_host_i (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
        .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // ********************************
    // tasks
    // ********************************
    task automatic close_out();
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d, output logic [31:0] q);
        wb_host_i.xfer(w, i, d, q);
        if (wb_host_i.late) begin
            error_cnt++;
            close_out();
        end
    endtask
    task automatic ck(input string n, input logic [7:0] i, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, i, 32'h00000000, q);
        `CHK(n, e, q)
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, i, d, q);
    endtask
    task automatic fire(input logic [7:0] w);
        @(posedge clk_i);
        ev <= w;
        @(posedge clk_i);
        ev <= 8'h00;
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk_i);
        `CHK("irq", e, irq_o)
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        {rst_i, ev, pst, tst, dst, rcf, rac, cx, cy, act, trig, lay} = {1'b1, 67'h0};
        {chan, cnt, p0, p1, tbit, comp} = 66'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        ck("state", 8'h04, 32'h00000000);
        pst <= 8'hA5;
        fire(8'h01);
        ck("prox", 8'h04, 32'h000000A5);
        {tst, dst} <= 16'h3C81;
        fire(8'h06);
        ck("touch", 8'h05, 32'h0000813C);
        {rcf, rac} <= 16'hF03C;
        fire(8'h08);
        ck("refuse", 8'h06, 32'h00000030);
        {tbit, comp} <= {3'h1, 11'h000};
        fire(8'h20);
        {tbit, comp} <= {3'h7, 11'h400};
        fire(8'h20);
        {tbit, comp} <= {3'h4, 11'h200};
        fire(8'h20);
        ck("comp", 8'h07, 32'h00008002);
        {tbit, comp} <= {3'h1, 11'h400};
        fire(8'h20);
        ck("retune", 8'h07, 32'h00008200);
        {cx, cy} <= 16'hC8FA;
        fire(8'h40);
        ck("xy6", 8'h08, 32'h0000FA80);
        lay <= 1'b1;
        fire(8'h40);
        ck("xy9", 8'h08, 32'h0000FAC8);
        {chan, cnt} <= {4'h0, 16'h0064};
        fire(8'h10);
        {cnt, trig} <= {16'h0074, 1'b1};
        fire(8'h10);
        ck("count", 8'h09, 32'h00000074);
        ck("avg", 8'h0A, 32'h00000065);
        ck("dirup", 8'h04, 32'h000001A5);
        {cnt, act} <= {16'h0030, 1'b1};
        fire(8'h10);
        ck("hold", 8'h0A, 32'h00000065);
        ck("dirdn", 8'h04, 32'h000000A5);
        {chan, cnt, trig} <= {4'h5, 16'h1234, 1'b0};
        fire(8'h10);
        ck("tpcnt", 8'h13, 32'h00001234);
        {p0, p1} <= 32'h01900064;
        fire(8'h80);
        ck("diff", 8'h23, 32'h0000012C);
        ck("common", 8'h24, 32'h000000FA);
        ck("plate0", 8'h25, 32'h00000190);
        ck("plate1", 8'h26, 32'h00000064);
        wr(8'h04, 32'h0000FFFF);
        ck("ro", 8'h04, 32'h000000A5);
        ck("unmap", 8'h3F, 32'h00000000);
        ck("stat", 8'h30, 32'h0000007F);
        irq_is(1'b0);
        wr(8'h31, 32'h00000001);
        irq_is(1'b1);
        wr(8'h32, 32'h00000001);
        irq_is(1'b0);
        ck("clr", 8'h30, 32'h0000007E);
        fire(8'h01);
        irq_is(1'b1);
        close_out();
    end
endmodule // test_sensor_channel_status_bank
`default_nettype wire
